// ---- rtl/sdrc_core.v ----
// sdram controller core: host bus, config port, command sequencer
`timescale 1ns/1ps
// What this block does
// R1 - host request strobe with select starts an sdram access sequence
// R2 - acknowledge pulses low once per read or write word
// R3 - config access strobe makes the sequencer perform a register write
// R4 - drive chip selects, row, column, write strobes, address and byte masks
// R5 - counters hold each command until its timing interval expires
// R6 - timing intervals come from software-written configuration registers
// R7 - host address splits into bank, row and column on memory lines
// R8 - reset loads default timing values, software may reprogram later
// R9 - registers set device size, burst length and timing
// R10 - host picks register by 2-bit index, 32-bit value, write strobe
// R11 - bursts of one to eight words and full page supported
// R12 - refresh cycles issued automatically at programmable interval
// R13 - one data word per clock during a burst, no waits
// R14 - four separate active-low memory chip selects; accesses reach only chips 0 and 1, chips 2 and 3 go low only on refresh
// R15 - host marks final word with last-beat so burst ends there
// R16 - address beyond configured size flags error, no sdram access
// R17 - data buffer direction and enable follow transfer direction
module sdrc_core (
    input  wire        clk_in,                 // system clock
    input  wire        rst_in,                 // async reset, active high
    input  wire        host_request_strobe_n_in, // access request strobe
    input  wire        host_select_n_in,       // host chip enable
    input  wire        host_write_in,          // 1 write, 0 read
    input  wire [31:0] host_addr_in,           // host word address
    input  wire [7:0]  host_byte_en_n_in,      // byte enables, active low
    input  wire        final_beat_n_in,        // last word of burst
    input  wire        cfg_access_req_n_in,    // config access strobe
    input  wire [1:0]  cfg_reg_index_in,       // config register index
    input  wire [31:0] cfg_write_value_in,     // config write value
    input  wire        cfg_write_strobe_in,    // config write qualifier
    output reg         cfg_ack_n_out,          // config write done
    output reg         xfer_ack_n_out,         // per-word acknowledge
    output reg         range_error_n_out,      // address out of range
    output reg         buf_oe_n_out,           // data buffer enable
    output reg         buf_to_mem_out,         // buffer direction, 1 to sdram
    output reg  [3:0]  mem_cs_n_out,           // chip selects
    output reg         mem_ras_n_out,          // row strobe
    output reg         mem_cas_n_out,          // column strobe
    output reg         mem_we_n_out,           // write strobe
    output reg  [1:0]  mem_bank_out,           // bank select
    output reg  [12:0] memory_row_col_lines_out, // row or column address
    output reg  [7:0]  mem_dqm_out             // byte lane masks
);
`include "sdrc_regs.vh"

// ==========================================================
// states and commands
localparam [3:0] ST_IDLE = 4'h0, ST_ACT = 4'h1, ST_RCD = 4'h2, ST_BURST = 4'h3,
                 ST_LAT = 4'h4, ST_RAS = 4'h5, ST_PRE = 4'h6, ST_REF = 4'h7,
                 ST_CFG = 4'h8, ST_ERR = 4'h9, ST_PREREF = 4'hA;
localparam [2:0] CMD_NOP = 3'h7, CMD_ACT = 3'h3, CMD_RD = 3'h5, CMD_WR = 3'h4,
                 CMD_PRE = 3'h2, CMD_REF = 3'h1;

// ==========================================================
// configuration registers
reg  [1:0]  size_r;   // 0..3: 2^(23+n) words addressable
reg  [3:0]  burst_r;
reg  [3:0]  trcd_r, tras_r, trp_r, tcl_r, trfc_r;
reg  [15:0] ref_int_r;
reg  [15:0] ref_cnt_r;
reg         ref_due_r;
reg  [3:0]  state_r;
reg  [3:0]  tmr_r;     // interval counter
reg  [3:0]  ras_r;     // activate to precharge counter
reg  [9:0]  beat_r;    // burst word counter
reg  [3:0]  lat_r;     // read latency drain
reg         wr_r;
reg  [31:0] addr_r;
reg  [15:0] rd_pipe_r; // read words in flight, one bit per clock
wire        hit_req = !host_request_strobe_n_in && !host_select_n_in;
wire [31:0] lim = 32'h0080_0000 << size_r;
wire        in_range = host_addr_in < lim;
wire [9:0]  blen = (burst_r == `SDRC_BURST_FULL) ? `SDRC_PAGE_LEN
                   : {6'h0, burst_r};
wire        last = !final_beat_n_in || (beat_r + 10'h1 >= blen);

// config writes, defaults on reset
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        size_r  <= `SDRC_SIZE_RST;                        // see R8
        burst_r <= `SDRC_BURST_RST;
        trcd_r  <= `SDRC_TRCD_RST;
        tras_r  <= `SDRC_TRAS_RST;
        trp_r   <= `SDRC_TRP_RST;
        tcl_r   <= `SDRC_TCL_RST;
        trfc_r  <= `SDRC_TRFC_RST;
        ref_int_r <= `SDRC_REF_RST;
    end else if (state_r == ST_CFG && cfg_write_strobe_in) begin  // see R3, R10
        case (cfg_reg_index_in)                            // see R9
            `SDRC_REG_SIZE: size_r <= cfg_write_value_in[1:0];
            `SDRC_REG_BURST: begin
                if (cfg_write_value_in[3:0] == 4'h0)
                    burst_r <= 4'h1;
                else if (cfg_write_value_in[3:0] > 4'h8)
                    burst_r <= `SDRC_BURST_FULL;               // see R11
                else
                    burst_r <= cfg_write_value_in[3:0];
            end
            `SDRC_REG_TIMING: begin                         // see R6
                trcd_r <= cfg_write_value_in[`SDRC_TRCD_LSB +: 4];
                tras_r <= cfg_write_value_in[`SDRC_TRAS_LSB +: 4];
                trp_r  <= cfg_write_value_in[`SDRC_TRP_LSB +: 4];
                tcl_r  <= cfg_write_value_in[`SDRC_TCL_LSB +: 4];
                trfc_r <= cfg_write_value_in[`SDRC_TRFC_LSB +: 4];
            end
            default: ref_int_r <= cfg_write_value_in[15:0];  // see R12
        endcase
    end
end

// refresh interval timer, set wins over clear
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        ref_cnt_r <= 16'h0000;
        ref_due_r <= 1'b0;
    end else begin
        if (ref_cnt_r >= ref_int_r) begin                   // see R12
            ref_cnt_r <= 16'h0000;
            ref_due_r <= 1'b1;
        end else begin
            ref_cnt_r <= ref_cnt_r + 16'h0001;
            if (state_r == ST_REF)
                ref_due_r <= 1'b0;
        end
    end
end

// ==========================================================
// sequencer with timing and burst counters
reg  [2:0]  cmd;
// command picked from the current state, registered onto the pins below
always @* begin
    cmd = CMD_NOP;
    case (state_r)
        ST_IDLE: begin
            if (ref_due_r)
                cmd = CMD_REF;                                // see R12
            else if (cfg_access_req_n_in && hit_req && in_range)
                cmd = CMD_ACT;                                // see R1
        end
        ST_BURST: cmd = wr_r ? CMD_WR : CMD_RD;               // see R13
        ST_RAS: if (ras_r <= 4'h1) cmd = CMD_PRE;
        default: cmd = CMD_NOP;
    endcase
end

// state, counters and registered pin drive
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        state_r <= ST_IDLE;
        tmr_r <= 4'h0;
        ras_r <= 4'h0;
        beat_r <= 10'h000;
        lat_r <= 4'h0;
        wr_r <= 1'b0;
        addr_r <= 32'h0000_0000;
        cfg_ack_n_out <= 1'b1;
        xfer_ack_n_out <= 1'b1;
        range_error_n_out <= 1'b1;
        buf_oe_n_out <= 1'b1;
        buf_to_mem_out <= 1'b0;
        mem_cs_n_out <= 4'hF;
        mem_ras_n_out <= 1'b1;
        mem_cas_n_out <= 1'b1;
        mem_we_n_out <= 1'b1;
        mem_bank_out <= 2'h0;
        memory_row_col_lines_out <= 13'h0000;
        mem_dqm_out <= 8'hFF;
    end else begin
        range_error_n_out <= 1'b1;                            // error pulse lasts one cycle
        cfg_ack_n_out <= 1'b1;
        xfer_ack_n_out <= 1'b1;
        if (tmr_r != 4'h0) tmr_r <= tmr_r - 4'h1;          // see R5
        if (ras_r != 4'h0) ras_r <= ras_r - 4'h1;
        case (state_r)
            ST_IDLE: begin
                range_error_n_out <= 1'b1;
                buf_oe_n_out <= 1'b1;
                if (ref_due_r) begin
                    tmr_r <= trfc_r;
                    state_r <= ST_REF;
                end else if (!cfg_access_req_n_in) begin
                    state_r <= ST_CFG;                        // see R3
                end else if (hit_req) begin                   // see R1
                    if (!in_range) begin
                        range_error_n_out <= 1'b0;            // see R16
                        state_r <= ST_ERR;
                    end else begin
                        addr_r <= host_addr_in;
                        wr_r <= host_write_in;
                        tmr_r <= trcd_r;
                        ras_r <= tras_r;
                        state_r <= ST_RCD;
                        buf_to_mem_out <= host_write_in;      // see R17
                        buf_oe_n_out <= 1'b0;
                    end
                end
            end
            ST_CFG: begin
                cfg_ack_n_out <= 1'b0;
                state_r <= ST_IDLE;
            end
            ST_ERR: state_r <= ST_IDLE;
            ST_RCD: if (tmr_r <= 4'h1) begin
                beat_r <= 10'h000;
                state_r <= ST_BURST;
            end
            ST_BURST: begin                                   // see R13
                beat_r <= beat_r + 10'h001;
                mem_dqm_out <= host_byte_en_n_in;
                if (wr_r)
                    xfer_ack_n_out <= 1'b0;                   // see R2
                if (last) begin                               // see R15
                    lat_r <= tcl_r;
                    state_r <= wr_r ? ST_RAS : ST_LAT;
                end
            end
            ST_LAT: begin
                if (lat_r == 4'h0) state_r <= ST_RAS;
                else lat_r <= lat_r - 4'h1;
            end
            ST_RAS: begin
                mem_dqm_out <= 8'hFF;
                if (ras_r <= 4'h1) begin
                    tmr_r <= trp_r;
                    state_r <= ST_PRE;
                end
            end
            ST_PRE: if (tmr_r <= 4'h1) begin
                buf_oe_n_out <= 1'b1;
                state_r <= ST_IDLE;
            end
            ST_REF: if (tmr_r <= 4'h1) state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
        endcase
        // read words return after cas latency, one ack per word
        if (rd_pipe_r[tcl_r])
            xfer_ack_n_out <= 1'b0;                           // see R2
        // command and address drive
        mem_ras_n_out <= cmd[2];                              // see R4
        mem_cas_n_out <= cmd[1];
        mem_we_n_out  <= cmd[0];
        mem_cs_n_out  <= 4'hF;
        if (cmd == CMD_REF)
            mem_cs_n_out <= 4'h0;
        else if (cmd != CMD_NOP)
            mem_cs_n_out <= ~(4'h1 << (cmd == CMD_ACT ? host_addr_in[26:25]
                                                      : addr_r[26:25])); // see R14
        if (cmd == CMD_ACT) begin                             // see R7
            mem_bank_out <= host_addr_in[24:23];
            memory_row_col_lines_out <= host_addr_in[22:10];
        end else if (cmd == CMD_PRE) begin
            memory_row_col_lines_out <= 13'h0400;             // all banks
        end else if (cmd != CMD_NOP) begin
            mem_bank_out <= addr_r[24:23];
            memory_row_col_lines_out <= {3'h0, addr_r[9:0] + beat_r};
        end
    end
end

// read acknowledge pipe: one low pulse per read word after cas latency
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
        rd_pipe_r <= 16'h0000;
    else
        rd_pipe_r <= {rd_pipe_r[14:0], state_r == ST_BURST && !wr_r};
end
endmodule

// ---- rtl/sdrc_regs.vh ----
// constants for the sdram controller core
`ifndef SDRC_REGS_VH
`define SDRC_REGS_VH
// configuration register indices
`define SDRC_REG_SIZE      2'h0
`define SDRC_REG_BURST     2'h1
`define SDRC_REG_TIMING    2'h2
`define SDRC_REG_REFRESH   2'h3
// reset values
`define SDRC_SIZE_RST      2'h3
`define SDRC_BURST_RST     4'h8
`define SDRC_TRCD_RST      4'h2
`define SDRC_TRAS_RST      4'h5
`define SDRC_TRP_RST       4'h2
`define SDRC_TCL_RST       4'h2
`define SDRC_TRFC_RST      4'h7
`define SDRC_REF_RST       16'h0186
// burst field code for full page
`define SDRC_BURST_FULL    4'hF
// page length in words for full page bursts
`define SDRC_PAGE_LEN      10'h200
// timing register field positions
`define SDRC_TRCD_LSB      0
`define SDRC_TRAS_LSB      4
`define SDRC_TRP_LSB       8
`define SDRC_TCL_LSB       12
`define SDRC_TRFC_LSB      16
`endif

// ---- verification/sdrc_core_chk.sv ----
// assertions on the ports of the sdram controller core
`timescale 1ns/1ps
module sdrc_chk (
    input wire        clk_in,                   // clock
    input wire        rst_in,                   // reset
    input wire [31:0] host_addr_in,             // host address
    input wire        cfg_access_req_n_in,      // config strobe
    input wire        cfg_ack_n_out,            // config done
    input wire        xfer_ack_n_out,           // word ack
    input wire        range_error_n_out,        // range error
    input wire        buf_oe_n_out,             // buffer enable
    input wire        buf_to_mem_out,           // buffer direction
    input wire [3:0]  mem_cs_n_out,             // chip selects
    input wire        mem_ras_n_out,            // row strobe
    input wire        mem_cas_n_out,            // column strobe
    input wire        mem_we_n_out,             // write strobe
    input wire [1:0]  mem_bank_out,             // bank
    input wire [12:0] memory_row_col_lines_out, // row or column
    input wire [7:0]  host_byte_en_n_in,        // byte enables
    input wire [7:0]  mem_dqm_out               // byte masks
);
    // command decode
    wire sel = mem_cs_n_out != 4'hF;
    wire act = sel && !mem_ras_n_out && mem_cas_n_out && mem_we_n_out;
    wire col = sel && mem_ras_n_out && !mem_cas_n_out;
    wire wrc = col && !mem_we_n_out;
    wire rdc = col && mem_we_n_out;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_write_ack: assert property (wrc |-> !xfer_ack_n_out) else $error("no ack with write");
    a_read_ack: assert property (rdc |-> ##[1:16] !xfer_ack_n_out)
        else $error("no read ack");
    a_dqm_copy: assert property (col |-> mem_dqm_out == $past(host_byte_en_n_in))
        else $error("bad byte mask");
    a_act_gap: assert property (act |=> !col) else $error("column too soon");
    a_act_addr: assert property (act |-> mem_bank_out == host_addr_in[24:23]
        && memory_row_col_lines_out == host_addr_in[22:10]
        && mem_cs_n_out == ~(4'h1 << host_addr_in[26:25])) else $error("bad act address");
    a_cs_single: assert property (col |-> $onehot(~mem_cs_n_out)) else $error("bad select");
    a_range_pulse: assert property (!range_error_n_out |=> range_error_n_out) else $error("long err");
    a_range_noact: assert property (!range_error_n_out |-> !act ##1 !act) else $error("act on err");
    a_cfg_answer: assert property ($fell(cfg_access_req_n_in) |-> ##[1:40] !cfg_ack_n_out)
        else $error("no config ack");
    a_cfg_pulse: assert property (!cfg_ack_n_out |=> cfg_ack_n_out) else $error("long config ack");
    a_buf_dir: assert property (wrc |-> !buf_oe_n_out && buf_to_mem_out) else $error("bad buffer");
endmodule
bind sdrc_core sdrc_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .host_addr_in(host_addr_in),
    .cfg_access_req_n_in(cfg_access_req_n_in), .cfg_ack_n_out(cfg_ack_n_out),
    .xfer_ack_n_out(xfer_ack_n_out), .range_error_n_out(range_error_n_out),
    .buf_oe_n_out(buf_oe_n_out), .buf_to_mem_out(buf_to_mem_out), .mem_cs_n_out(mem_cs_n_out),
    .mem_ras_n_out(mem_ras_n_out), .mem_cas_n_out(mem_cas_n_out), .mem_we_n_out(mem_we_n_out),
    .mem_bank_out(mem_bank_out), .memory_row_col_lines_out(memory_row_col_lines_out),
    .host_byte_en_n_in(host_byte_en_n_in), .mem_dqm_out(mem_dqm_out));

// ---- verification/sdrc_core_test.sv ----
// self-checking bench for the sdram controller core
`timescale 1ns/1ps
module sdrc_core_test;
    reg clk_in = 0, rst_in = 1, req_n = 1, sel_n = 1, wr = 0, creq_n = 1, cwr = 0, fin_n = 1;
    reg [31:0] addr = 32'h0, cval = 32'h0;
    reg [7:0]  be_n = 8'h0;
    reg [1:0]  cidx = 2'h0;
    wire cfg_ack_n, xfer_ack_n, range_error_n, buf_oe_n, ras_n, cas_n, we_n;
    wire [3:0] cs_n;
    int n_mismatch = 0, comparisons = 0, cycles = 0, run = 0, refs, gap, i, stop_at = 0;
    logic [15:0] q[$];
    sdrc_core DUT (.clk_in(clk_in), .rst_in(rst_in), .host_request_strobe_n_in(req_n),
        .host_select_n_in(sel_n), .host_write_in(wr), .host_addr_in(addr),
        .host_byte_en_n_in(be_n), .final_beat_n_in(fin_n), .cfg_access_req_n_in(creq_n),
        .cfg_reg_index_in(cidx), .cfg_write_value_in(cval), .cfg_write_strobe_in(cwr),
        .cfg_ack_n_out(cfg_ack_n), .xfer_ack_n_out(xfer_ack_n), .range_error_n_out(range_error_n),
        .buf_oe_n_out(buf_oe_n), .buf_to_mem_out(), .mem_cs_n_out(cs_n), .mem_ras_n_out(ras_n),
        .mem_cas_n_out(cas_n), .mem_we_n_out(we_n), .mem_bank_out(),
        .memory_row_col_lines_out(), .mem_dqm_out());
    sdrc_mem_model u_mem (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .ras_n_in(ras_n),
        .cas_n_in(cas_n), .we_n_in(we_n), .ref_cnt_out(refs), .act_gap_out(gap));
    // =====================================
    // clock and hang limit
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test;
        end
    end
    task check(input [15:0] got, input [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        if (q.size() != 0) n_mismatch++;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // config write, held until the one-cycle ack is seen
    task cfg(input [1:0] idx, input [31:0] v);
        int k;
        @(negedge clk_in);
        creq_n = 0; cwr = 1; cidx = idx; cval = v;
        for (k = 0; k < 50 && cfg_ack_n !== 1'b0; k++) @(negedge clk_in);
        creq_n = 1; cwr = 0;
    endtask
    // host access, strobe held until activate or range error, then wait for idle
    // a non-zero stop_at marks that write word as the last one
    task acc(input w, input [31:0] a, input [15:0] e);
        int k, nb;
        @(negedge clk_in);
        q.push_back(e);
        req_n = 0; sel_n = 0; wr = w; addr = a; be_n = 8'($urandom);
        for (k = 0; k < 50 && !(cs_n != 4'hF && !ras_n && cas_n) && range_error_n !== 1'b0; k++)
            @(negedge clk_in);
        req_n = 1; sel_n = 1;
        nb = 0;
        for (k = 0; k < 700 && buf_oe_n !== 1'b1; k++) begin
            if (xfer_ack_n === 1'b0) nb++;
            fin_n = !(stop_at != 0 && nb + 1 == stop_at);
            @(negedge clk_in);
        end
        fin_n = 1;
    endtask
    // =====================================
    // result watcher: ack run lengths and range errors against the notes
    always @(posedge clk_in) begin
        if (!rst_in) begin
            if (xfer_ack_n === 1'b0) run++;
            else if (run != 0) begin
                check(run[15:0], q.pop_front());
                run = 0;
            end
            if (range_error_n === 1'b0) check(16'hE000, q.pop_front());
        end
    end
    initial begin
        void'($urandom(77));
        repeat (2) @(posedge clk_in);
        @(negedge clk_in) rst_in = 0;
        acc(1, $urandom & 32'h03FF_FFFF, 16'h8);
        // column goes out one clock after the row timer runs out
        check(gap[15:0], 16'h3);
        cfg(2'h3, 32'h0000_FFFF);
        $display("defaults test done");
        for (i = 1; i <= 9; i++) begin
            cfg(2'h1, (i == 9) ? 32'hF : i);
            acc(1, $urandom & 32'h03FF_FFFF, (i == 9) ? 16'h200 : 16'(i));
        end
        stop_at = 3;
        acc(1, $urandom & 32'h03FF_FFFF, 16'h3);
        stop_at = 0;
        $display("burst test done");
        cfg(2'h1, 32'h1);
        cfg(2'h2, 32'h0007_2284);
        acc(1, $urandom & 32'h03FF_FFFF, 16'h1);
        // programmed delay of four plus the one clock after expiry
        check(gap[15:0], 16'h5);
        cfg(2'h1, 32'h4);
        acc(0, $urandom & 32'h03FF_FFFF, 16'h4);
        $display("timing and read test done");
        cfg(2'h0, 32'h0);
        acc(1, 32'h0080_0000, 16'hE000);
        acc(1, 32'h007F_FFFF, 16'h4);
        cfg(2'h0, 32'h3);
        $display("range test done");
        i = refs;
        cfg(2'h3, 32'h0000_0020);
        repeat (320) @(negedge clk_in);
        check({15'h0, (refs - i >= 6) && (refs - i <= 11)}, 16'h1);
        cfg(2'h3, 32'h0000_FFFF);
        $display("refresh test done");
        finish_test;
    end
endmodule

// ---- verification/sdrc_mem_model.sv ----
// sdram side model: decodes commands, counts refreshes, times act to column
`timescale 1ns/1ps
module sdrc_mem_model (
    input  wire       clk_in,       // system clock
    input  wire       rst_in,       // async reset
    input  wire [3:0] cs_n_in,      // chip selects
    input  wire       ras_n_in,     // row strobe
    input  wire       cas_n_in,     // column strobe
    input  wire       we_n_in,      // write strobe
    output int        ref_cnt_out,  // refreshes seen
    output int        act_gap_out   // last act to column distance
);
    int since_r;
    // =====================================
    // command decode, only while a chip is selected
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ref_cnt_out <= 0;
            act_gap_out <= 0;
            since_r <= 0;
        end else begin
            if (since_r != 0) since_r <= since_r + 1;
            if (cs_n_in != 4'hF) begin
                if (!ras_n_in && cas_n_in && we_n_in) since_r <= 1;
                else if (!ras_n_in && !cas_n_in && we_n_in) ref_cnt_out <= ref_cnt_out + 1;
                else if (ras_n_in && !cas_n_in && since_r != 0) begin
                    act_gap_out <= since_r;
                    since_r <= 0;
                end
            end
        end
    end
endmodule
